// >>> pkg/ddr2b_pkg.sv
// package: shared constants and types for the two-word burst ddr sram port
package ddr2b_pkg;
  // data organisation: two byte lanes of nine bits per word
  localparam int WORD_W = 18;
  localparam int BYTE_W = 9;
  localparam int BYTES  = 2;
  localparam int BURST  = 2;
  // read pipeline depth and stages, counted in input clock edges after the command
  localparam int PIPE_DEPTH = 6;
  localparam int PLL_W0     = 4;
  localparam int PLL_W1     = 5;
  localparam int FB_W0      = 1;
  localparam int FB_W1      = 2;
  localparam int VLD_LEAD   = 1;
  // core clock period
  localparam int CLK_NS = 25;
  // pll lock time after a stable clock, and least clock stop that resets it
  localparam int PLL_LOCK_US  = 100;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PLL_STOP_NS  = 30;
  localparam int PLL_STOP_CYC = (PLL_STOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOCK_W       = $clog2(PLL_LOCK_CYC + 1);
  localparam int GAP_W        = 8;
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(PLL_LOCK_CYC - 1);
  // reset values
  localparam logic [WORD_W-1:0] DQ_RST = 18'h00000;
  // write collector states
  typedef enum logic [1:0]
  {
    COL_IDLE  = 2'b01,
    COL_WORD1 = 2'b10
  } ddr2b_col_t;
endpackage

// >>> hw/ddr2b_sync.sv
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module ddr2b_sync #(
  parameter int WIDTH = 1
)(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // bundle
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // ddr2b_sync
`default_nettype wire

// >>> hw/ddr2b_array.sv
// storage array: one location holds a two-word burst, byte-lane write enables
`timescale 1ns/1ps
`default_nettype none
module ddr2b_array
  import ddr2b_pkg::*;
#(
  parameter int ADDR_W = 21
)(
  // clock
  input  wire logic                      clk,
  // write port
  input  wire logic                      we,
  input  wire logic [ADDR_W-1:0]         waddr,
  input  wire logic [BURST*WORD_W-1:0]   wdata,
  input  wire logic [BURST*BYTES-1:0]    wbe,
  // read port
  input  wire logic [ADDR_W-1:0]         raddr,
  output logic      [BURST*WORD_W-1:0]   rdata
);
  logic [BURST*WORD_W-1:0] mem [2**ADDR_W];

  // lanes with a cleared enable keep their stored value
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      for (int b = 0; b < BURST*BYTES; b++)
      begin
        if (wbe[b])
          mem[waddr][b*BYTE_W +: BYTE_W] <= wdata[b*BYTE_W +: BYTE_W];
      end
    end
  end

  // asynchronous read, sampled by the output registers of the port
  assign rdata = mem[raddr];
endmodule // ddr2b_array
`default_nettype wire

// >>> hw/ddr2b_port.sv
// synchronous port logic of a double-data-rate two-word burst sram
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - each access moves two consecutive 18-bit words
// - read command: select high, strobe low
// - pll on: first read word at k_n t+2
// - second read word at next k rise
// - reads accepted on every k rise
// - finish bursts, then float after k_n rise (pll on) or k rise (pll off)
// - write command: select low, strobe low
// - first write word taken at k t+1
// - second word at k_n, 36 bits committed
// - writes accepted on every k rise
// - deselected writes finish, then inputs ignored
// - byte selects sampled with each word
// - deselected bytes keep stored contents
// - write held in posted registers until next write
// - reads of posted address forward newest data
// - two free-running echo clocks follow inputs
// - valid flag leads read data half cycle
// - pll locks 100 us after stable clock
// - pll disabled: one-cycle read latency
// - outputs float after reset until a read command
module ddr2b_port
  import ddr2b_pkg::*;
#(
  parameter int ADDR_W  = 21,
  parameter int GAP_MAX = 2
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // input clock pair from the controller
  input  wire logic              k_clk,
  input  wire logic              k_clk_n,
  // command and byte selects
  input  wire logic              load_strobe_n,
  input  wire logic              read_write_select,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [BYTES-1:0]  byte_write_select_n,
  // shared data pin
  input  wire logic [WORD_W-1:0] dq_in,
  output logic      [WORD_W-1:0] dq_out,
  output logic                   dq_oe_n,
  // capture aids
  output logic                   output_valid_flag,
  output logic                   echo_clock,
  output logic                   echo_clock_n,
  // pll
  input  wire logic              pll_disable_n,
  output logic                   pll_locked
);
  localparam int SW = 4 + ADDR_W + BYTES + WORD_W + 1;
  localparam logic [GAP_W-1:0] GAP_LIM = GAP_W'(GAP_MAX + PLL_STOP_CYC);

  logic [SW-1:0]           raw;
  logic [SW-1:0]           syn;
  logic                    k_s;
  logic                    kn_s;
  logic                    ld_n_s;
  logic                    rw_s;
  logic [ADDR_W-1:0]       addr_s;
  logic [BYTES-1:0]        bws_n_s;
  logic [WORD_W-1:0]       dq_s;
  logic                    pll_disable_n_n_s;
  logic                    k_rise;
  logic                    kn_rise;
  logic                    any_edge;
  logic                    rd_cmd;
  logic                    wr_cmd;
  logic                    fallback;
  logic [PIPE_DEPTH-1:0]   rd_v;
  logic [ADDR_W-1:0]       rd_a [PIPE_DEPTH];
  logic                    do_w0;
  logic                    do_w1;
  logic                    vld_on;
  logic [ADDR_W-1:0]       rd_sel_a;
  logic [BURST*WORD_W-1:0] arr_q;
  logic [BURST*WORD_W-1:0] merged;
  logic                    fwd_hit;
  logic [WORD_W-1:0]       rd_word;
  logic                    wa_v;
  logic [ADDR_W-1:0]       wa_a;
  ddr2b_col_t              col_st;
  logic [ADDR_W-1:0]       col_a;
  logic [WORD_W-1:0]       col_d;
  logic [BYTES-1:0]        col_be;
  logic                    col_done;
  logic                    pw_v;
  logic [ADDR_W-1:0]       pw_a;
  logic [BURST*WORD_W-1:0] pw_d;
  logic [BURST*BYTES-1:0]  pw_be;
  logic                    arr_we;
  logic [GAP_W-1:0]        gap;
  logic [LOCK_W-1:0]       lock_cnt;

  // overlay the enabled posted lanes on a location read from the array
  function automatic logic [BURST*WORD_W-1:0] fwd_merge(
    input logic [BURST*WORD_W-1:0] arr,
    input logic [BURST*WORD_W-1:0] pd,
    input logic [BURST*BYTES-1:0]  be,
    input logic                    hit
  );
    logic [BURST*WORD_W-1:0] m;
    m = arr;
    for (int b = 0; b < BURST*BYTES; b++)
    begin
      if (hit && be[b])
        m[b*BYTE_W +: BYTE_W] = pd[b*BYTE_W +: BYTE_W];
    end
    return m;
  endfunction

  // every pin passes two flops, all with the same delay so they stay aligned
  assign raw = {k_clk, k_clk_n, load_strobe_n, read_write_select, addr,
                byte_write_select_n, dq_in, pll_disable_n};
  ddr2b_sync #(.WIDTH (SW)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (raw),
    .q   (syn)
  );

  assign {k_s, kn_s, ld_n_s, rw_s, addr_s, bws_n_s, dq_s, pll_disable_n_n_s} = syn;

  // echo registers double as the delayed copy for edge detection
  assign k_rise   = k_s & ~echo_clock;
  assign kn_rise  = kn_s & ~echo_clock_n;
  assign any_edge = k_rise | kn_rise;
  assign rd_cmd   = k_rise & ~ld_n_s & rw_s;
  assign wr_cmd   = k_rise & ~ld_n_s & ~rw_s;
  assign fallback = ~pll_disable_n_n_s;

  // echo clocks run free and track the input pair
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      echo_clock   <= 1'b0;
      echo_clock_n <= 1'b0;
    end
    else
    begin
      echo_clock   <= k_s;
      echo_clock_n <= kn_s;
    end
  end

  // read pipeline advances one stage per input clock edge; a slot per k rise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_v <= '0;
    else if (any_edge)
      rd_v <= {rd_v[PIPE_DEPTH-2:0], rd_cmd};
  end

  // read address register travels with its burst
  always_ff @(posedge clk)
  begin
    if (any_edge)
    begin
      rd_a[0] <= addr_s;
      for (int i = 1; i < PIPE_DEPTH; i++)
        rd_a[i] <= rd_a[i-1];
    end
  end

  // stage taps for the two latency modes
  assign do_w0  = fallback ? rd_v[FB_W0] : rd_v[PLL_W0];
  assign do_w1  = fallback ? rd_v[FB_W1] : rd_v[PLL_W1];
  assign vld_on = fallback ? (rd_v[FB_W0-VLD_LEAD] | rd_v[FB_W0])
                           : (rd_v[PLL_W0-VLD_LEAD] | rd_v[PLL_W0]);

  // commands only on k rises, so both taps are never live at once
  assign rd_sel_a = fallback ? (do_w0 ? rd_a[FB_W0] : rd_a[FB_W1])
                             : (do_w0 ? rd_a[PLL_W0] : rd_a[PLL_W1]);

  ddr2b_array #(.ADDR_W (ADDR_W)) u_array (
    .clk   (clk),
    .we    (arr_we),
    .waddr (pw_a),
    .wdata (pw_d),
    .wbe   (pw_be),
    .raddr (rd_sel_a),
    .rdata (arr_q)
  );

  // posted write bypasses the array for the newest data
  assign fwd_hit = pw_v && (pw_a == rd_sel_a);
  assign merged  = fwd_merge(arr_q, pw_d, pw_be, fwd_hit);
  assign rd_word = do_w0 ? merged[WORD_W-1:0] : merged[BURST*WORD_W-1:WORD_W];

  // data pin drive: words on their edges, float on the next edge without one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dq_out  <= DQ_RST;
      dq_oe_n <= 1'b1;
    end
    else if (any_edge)
    begin
      if (do_w0 || do_w1)
      begin
        dq_out  <= rd_word;
        dq_oe_n <= 1'b0;
      end
      else
        dq_oe_n <= 1'b1;
    end
  end

  // valid flag is registered on the same edges as the data, half a cycle ahead
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      output_valid_flag <= 1'b0;
    else if (any_edge)
      output_valid_flag <= vld_on;
  end

  // write address register; data follows one k cycle later
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wa_v <= 1'b0;
      wa_a <= '0;
    end
    else if (k_rise)
    begin
      wa_v <= wr_cmd;
      if (wr_cmd)
        wa_a <= addr_s;
    end
  end

  // collector: first word at the next k rise, second at the k_n rise after it
  assign col_done = kn_rise && (col_st == COL_WORD1);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      col_st <= COL_IDLE;
      col_a  <= '0;
      col_d  <= '0;
      col_be <= '0;
    end
    else
    begin
      case (col_st)
        COL_IDLE:
        begin
          if (k_rise && wa_v)
          begin
            col_a  <= wa_a;
            col_d  <= dq_s;
            col_be <= ~bws_n_s;
            col_st <= COL_WORD1;
          end
        end
        COL_WORD1:
        begin
          if (kn_rise)
            col_st <= COL_IDLE;
        end
        default:
          col_st <= COL_IDLE;
      endcase
    end
  end

  // a completed burst becomes the posted write; the older one goes to the array
  assign arr_we = col_done && pw_v;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pw_v  <= 1'b0;
      pw_a  <= '0;
      pw_d  <= '0;
      pw_be <= '0;
    end
    else if (col_done)
    begin
      pw_v  <= 1'b1;
      pw_a  <= col_a;
      pw_d  <= {dq_s, col_d};
      pw_be <= {~bws_n_s, col_be};
    end
  end

  // edge gap detects a slowed or stopped input clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      gap <= '0;
    else if (any_edge)
      gap <= '0;
    else if (gap <= GAP_LIM)
      gap <= gap + 1'b1;  // saturates just past the limit
  end

  // lock counter restarts on a stopped clock or with the pll turned off
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lock_cnt   <= '0;
      pll_locked <= 1'b0;
    end
    else if (fallback || gap > GAP_LIM)
    begin
      lock_cnt   <= '0;
      pll_locked <= 1'b0;
    end
    else if (lock_cnt == LOCK_LAST)
      pll_locked <= 1'b1;
    else
      lock_cnt <= lock_cnt + 1'b1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  rd_first_word_a: assert property (
    any_edge && !fallback && rd_v[PLL_W0] |=> !dq_oe_n && dq_out == $past(rd_word))
    else $error("first read word not driven on its edge");
  rd_second_word_a: assert property (
    any_edge && !fallback && rd_v[PLL_W1] |=> !dq_oe_n && dq_out == $past(rd_word))
    else $error("second read word not driven on its edge");
  fallback_latency_a: assert property (
    any_edge && fallback && rd_v[FB_W0] |=> !dq_oe_n)
    else $error("fallback read word late");
  valid_lead_a: assert property (
    any_edge && !fallback && rd_v[PLL_W0-VLD_LEAD] |=> output_valid_flag && dq_oe_n == $past(!do_w0 && !do_w1))
    else $error("valid flag does not lead the data");
  float_after_a: assert property (
    any_edge && !do_w0 && !do_w1 |=> dq_oe_n)
    else $error("data pin driven without a burst word");
  echo_track_a: assert property (
    $rose(k_s) |=> $rose(echo_clock) ##1 !$fell(echo_clock) || !k_s)
    else $error("echo clock does not follow input clock");
  posted_hold_a: assert property (
    rd_cmd && pw_v && !col_done |=> pw_v && $stable(pw_a) && $stable(pw_d))
    else $error("posted write lost on a read");
  commit_word_a: assert property (
    col_done |=> pw_v && pw_a == $past(col_a) && pw_d[WORD_W-1:0] == $past(col_d))
    else $error("completed burst not posted");
  byte_keep_a: assert property (
    col_done && bws_n_s[0] |=> !pw_be[BYTES])
    else $error("deselected byte enabled for write");
  pll_lock_a: assert property (
    $rose(pll_locked) |-> $past(lock_cnt) == LOCK_LAST && !fallback)
    else $error("pll lock asserted early");

  // k rises are several core cycles apart, so the window spans a few input periods
  back_to_back_c: cover property (rd_cmd ##[1:24] rd_cmd);
  forward_hit_c: cover property (any_edge && (do_w0 || do_w1) && fwd_hit);
  fallback_read_c: cover property (fallback && rd_cmd);
  lock_c: cover property ($rose(pll_locked));
endmodule // ddr2b_port
`default_nettype wire

// >>> bench/ddr2b_ctrl_model.sv
// controller-side model: input clocks, command pins, write words and a reference memory
`timescale 1ns/1ps
`default_nettype none
module ddr2b_ctrl_model
  import ddr2b_pkg::*;
#(
  parameter int ADDR_W = 21
)(
  // clock and controls from the bench
  input  wire logic              clk,
  input  wire logic              k_run,
  input  wire logic              pll_disable_n,
  // pins toward the device
  output logic                   k_clk,
  output logic                   k_clk_n,
  output logic                   load_strobe_n,
  output logic                   read_write_select,
  output logic      [ADDR_W-1:0] addr,
  output logic      [BYTES-1:0]  byte_write_select_n,
  output logic      [WORD_W-1:0] dq_drv
);
  typedef struct {int s; logic [WORD_W-1:0] d; logic [BYTES-1:0] b;} ddr2b_wrd_t;
  typedef struct {logic rd; int a; logic [2*WORD_W-1:0] d; logic [2*BYTES-1:0] b;} ddr2b_cmd_t;
  int                  ph      = 0;
  int                  slot    = 0;
  int                  last_rd = -100;
  ddr2b_wrd_t          wq[$];
  ddr2b_wrd_t          eq[$];
  ddr2b_cmd_t          cq[$];
  logic [2*WORD_W-1:0] mem[int];

  // idle levels before the first edge
  initial
  begin
    {k_clk, k_clk_n, load_strobe_n, read_write_select} = 4'h6;
    addr = '0;
    byte_write_select_n = '1;
    dq_drv = '0;
  end

  task automatic put(input logic rd, input int a, input logic [2*WORD_W-1:0] d, input logic [3:0] b);
    cq.push_back('{rd, a, d, b});
  endtask

  function automatic logic due(input int s);
    return (eq.size() > 0 && eq[0].s == s) || (eq.size() > 1 && eq[1].s == s);
  endfunction

  function automatic logic [WORD_W-1:0] take();
    ddr2b_wrd_t w;
    w = eq.pop_front();
    return w.d;
  endfunction

  function automatic logic busy();
    return cq.size() > 0 || eq.size() > 0 || wq.size() > 0;
  endfunction

  // pins for input edge s, set three core cycles ahead so they stand still around it
  task automatic drive(input int s);
    ddr2b_cmd_t c;
    int         l;
    if (wq.size() > 0 && wq[0].s == s)
    begin
      dq_drv <= wq[0].d;
      byte_write_select_n <= wq[0].b;
      wq.delete(0);
    end
    else
    begin
      dq_drv <= ~dq_drv;
      byte_write_select_n <= BYTES'($urandom);
    end
    // a write waits out the read-to-write idles, three of them for margin
    if (s % 2 == 0 && cq.size() > 0 && (cq[0].rd || s - last_rd >= 8))
    begin
      c = cq.pop_front();
      load_strobe_n <= 1'b0;
      read_write_select <= c.rd;
      addr <= ADDR_W'(c.a);
      if (c.rd)
      begin
        l = pll_disable_n ? 5 : 2;
        last_rd = s;
        eq.push_back('{s + l, mem[c.a][WORD_W-1:0], '0});
        eq.push_back('{s + l + 1, mem[c.a][2*WORD_W-1:WORD_W], '0});
      end
      else
      begin
        wq.push_back('{s + 2, c.d[WORD_W-1:0], c.b[1:0]});
        wq.push_back('{s + 3, c.d[2*WORD_W-1:WORD_W], c.b[3:2]});
        for (int i = 0; i < 2 * BYTES; i++)
          if (!c.b[i])
            mem[c.a][i*BYTE_W +: BYTE_W] = c.d[i*BYTE_W +: BYTE_W];
      end
    end
    else
    begin
      load_strobe_n <= 1'b1;
      read_write_select <= 1'($urandom);
      addr <= ADDR_W'($urandom);
    end
  endtask

  // twelve core cycles per input clock; stopping it freezes both pins
  always @(negedge clk)
  begin
    if (k_run)
    begin
      ph = (ph == 11) ? 0 : ph + 1;
      if (ph == 0 || ph == 6)
      begin
        k_clk <= (ph == 0);
        k_clk_n <= (ph == 6);
        slot++;
      end
      if (ph == 3 || ph == 9)
        drive(slot + 1);
    end
  end
endmodule // ddr2b_ctrl_model
`default_nettype wire

// >>> bench/tb_ddr_burst2_sram_port.sv
// testbench: port driven through the controller model, read words, flags and pll state checked
`timescale 1ns/1ps
`default_nettype none
module tb_ddr_burst2_sram_port
  import ddr2b_pkg::*;
;
  logic              clk           = 1'b0;
  logic              rst           = 1'b1;
  logic              k_run         = 1'b1;
  logic              pll_disable_n = 1'b1;
  logic              mon           = 1'b0;
  logic              k_clk, k_clk_n, load_strobe_n, read_write_select;
  logic [20:0]       addr;
  logic [BYTES-1:0]  byte_write_select_n;
  logic [WORD_W-1:0] dq_drv, dq_in, dq_out, w;
  logic              dq_oe_n, output_valid_flag, echo_clock, echo_clock_n, pll_locked;
  int                miscompares = 0;
  int                checks_done = 0;
  int                cur, n;

  // shared pin: the device wins while it drives
  assign dq_in = (dq_oe_n === 1'b0) ? dq_out : dq_drv;

  // 40 MHz core clock
  initial
    forever #12.5 clk = ~clk;

  ddr2b_ctrl_model #(.ADDR_W(21)) i_ddr2b_ctrl_model (.clk(clk), .k_run(k_run),
    .pll_disable_n(pll_disable_n), .k_clk(k_clk), .k_clk_n(k_clk_n), .load_strobe_n(load_strobe_n),
    .read_write_select(read_write_select), .addr(addr), .byte_write_select_n(byte_write_select_n),
    .dq_drv(dq_drv));

  // input edges come every six core cycles here, so the gap limit must allow six
  ddr2b_port #(.ADDR_W(21), .GAP_MAX(6)) i_ddr2b_port (.clk(clk), .rst(rst), .k_clk(k_clk),
    .k_clk_n(k_clk_n), .load_strobe_n(load_strobe_n), .read_write_select(read_write_select),
    .addr(addr), .byte_write_select_n(byte_write_select_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .output_valid_flag(output_valid_flag), .echo_clock(echo_clock),
    .echo_clock_n(echo_clock_n), .pll_disable_n(pll_disable_n), .pll_locked(pll_locked));

  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic close_out();
    chk(!i_ddr2b_ctrl_model.busy(), "read words never delivered");
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic op(input logic rd, input int a, input logic [3:0] b);
    i_ddr2b_ctrl_model.put(rd, a, 36'({$urandom, $urandom}), b);
  endtask

  task automatic drain();
    for (n = 0; n < 5000 && i_ddr2b_ctrl_model.busy(); n++)
      @(negedge clk);
    repeat (24) @(negedge clk);
  endtask

  // one look per input edge, mid-way through the span the registered outputs stand
  always @(posedge clk)
  begin
    if (mon && (i_ddr2b_ctrl_model.ph == 5 || i_ddr2b_ctrl_model.ph == 11))
    begin
      cur = i_ddr2b_ctrl_model.slot;
      chk(output_valid_flag === i_ddr2b_ctrl_model.due(cur + 1), "valid flag");
      chk(echo_clock === k_clk && echo_clock_n === k_clk_n, "echo clocks");
      if (i_ddr2b_ctrl_model.due(cur))
      begin
        w = i_ddr2b_ctrl_model.take();
        chk(dq_oe_n === 1'b0 && dq_out === w, "read word");
      end
      else
        chk(dq_oe_n === 1'b1, "data bus not floated");
    end
  end

  // main sequence
  initial
  begin
    void'($urandom(32'ha58b));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (12) @(negedge clk);
    mon = 1'b1;
    repeat (PLL_LOCK_CYC - 112) @(negedge clk);
    chk(pll_locked === 1'b0, "locked too early");
    repeat (200) @(negedge clk);
    chk(pll_locked === 1'b1, "never locked");
    // back-to-back full writes, an instant read-back, then back-to-back reads
    for (int i = 0; i < 8; i++)
      op(1'b0, i, 4'h0);
    op(1'b1, 7, 4'h0);
    for (int i = 0; i < 8; i++)
      op(1'b1, i, 4'h0);
    // every byte-select pair on both words, then read all back
    for (int i = 0; i < 16; i++)
      op(1'b0, i % 8, 4'(i));
    for (int i = 0; i < 8; i++)
      op(1'b1, i, 4'h0);
    // random mix exercises posted writes and forwarding
    repeat (60) op(1'($urandom), $urandom % 8, 4'($urandom));
    drain();
    // stopped input clocks drop the lock
    mon = 1'b0;
    k_run = 1'b0;
    repeat (20) @(negedge clk);
    chk(pll_locked === 1'b0, "lock kept with clocks stopped");
    k_run = 1'b1;
    repeat (12) @(negedge clk);
    mon = 1'b1;
    // fallback mode: one-cycle read latency, no lock
    pll_disable_n = 1'b0;
    repeat (24) @(negedge clk);
    chk(pll_locked === 1'b0, "locked in fallback");
    repeat (30) op(1'($urandom), $urandom % 8, 4'($urandom));
    drain();
    close_out();
  end

  // watchdog well beyond the longest expected run
  initial
  begin
    repeat (30000) @(posedge clk);
    chk(1'b0, "watchdog expired");
    close_out();
  end
endmodule // tb_ddr_burst2_sram_port
`default_nettype wire
